// ### iec_consts.vh
// Constants for the interface and enable control register bank
`ifndef IEC_CONSTS_VH
`define IEC_CONSTS_VH

// Register addresses on the special-function bus
`define IEC_ADDR_HOST_IF        8'hd4
`define IEC_ADDR_ENABLES        8'hd5
`define IEC_ADDR_CLK_GATE       8'hd6
`define IEC_ADDR_SELFTEST_STAT  8'hd7

// Reset values
`define IEC_RST_HOST_IF         8'h00
`define IEC_RST_ENABLES         8'h00
`define IEC_RST_CLK_GATE        8'h00

// Writable bit masks, upper bits read as zero
`define IEC_MASK_HOST_IF        8'h0f
`define IEC_MASK_ENABLES        8'h1f
`define IEC_MASK_CLK_GATE       8'h07

// Host interface control fields
`define IEC_HIF_SEL_LSB         0
`define IEC_HIF_SEL_MSB         1
`define IEC_HIF_XCR_BIT         2
`define IEC_HIF_DEGLITCH_BIT    3

// Interface select codes
`define IEC_SEL_SPI             2'h0
`define IEC_SEL_I2C             2'h1
`define IEC_SEL_SINGLE_WIRE     2'h2
`define IEC_SEL_SPI_ALT         2'h3

// Monitor and test enable fields
`define IEC_EN_SW_WD_BIT        0
`define IEC_EN_OSC_WD_BIT       1
`define IEC_EN_CAP_MON_BIT      2
`define IEC_EN_LOOPBACK_BIT     3
`define IEC_EN_INT_CAPS_BIT     4

// Clock gate and self-test fields
`define IEC_CG_EEPROM_BIT       0
`define IEC_CG_HOST_IF_BIT      1
`define IEC_CG_SELFTEST_BIT     2

// Self-test status fields
`define IEC_ST_DONE_BIT         0
`define IEC_ST_FAIL_BIT         1

// Timing
`define IEC_CLK_MHZ             200
`define IEC_NCS_TIME_NS         500
`define IEC_NCS_CYCLES          ((`IEC_NCS_TIME_NS * `IEC_CLK_MHZ + 999) / 1000)
`define IEC_NCS_CNT_W           8
`define IEC_DEGLITCH_SHORT_MS   1
`define IEC_DEGLITCH_LONG_MS    10
`define IEC_DEGLITCH_SHORT_CYC  (`IEC_DEGLITCH_SHORT_MS * `IEC_CLK_MHZ * 1000)
`define IEC_DEGLITCH_LONG_CYC   (`IEC_DEGLITCH_LONG_MS * `IEC_CLK_MHZ * 1000)
`define IEC_DEGLITCH_CNT_W      21

`endif

// ### iec_ncs_filter.v
// Chip-select low-time detector that wakes the host interface clock
`timescale 1ns/10ps
`include "iec_consts.vh"

module iec_ncs_filter
(
	// Clock and reset
	input  wire i_ref_clk,
	input  wire i_rst,
	// Chip select, active low
	input  wire i_spi_chip_select_low_n,
	// One-cycle wake pulse
	output reg  o_wake
);

	// Trimmed on purpose: the low-time count fits the counter width
	localparam                      NCS_FULL  = `IEC_NCS_CYCLES;
	localparam [`IEC_NCS_CNT_W-1:0] NCS_LIMIT = NCS_FULL[`IEC_NCS_CNT_W-1:0];

	reg [`IEC_NCS_CNT_W-1:0] low_count;

	////////////////////////////////////////////////////////////////////////
	// Pulses once per low period, so noise shorter than the limit is ignored
	always @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			low_count <= {`IEC_NCS_CNT_W{1'b0}};
			o_wake    <= 1'b0;
		end
		else if (i_spi_chip_select_low_n)
		begin
			low_count <= {`IEC_NCS_CNT_W{1'b0}};
			o_wake    <= 1'b0;
		end
		else if (low_count < NCS_LIMIT)
		begin
			low_count <= low_count + 1'b1;
			o_wake    <= (low_count == NCS_LIMIT - 1'b1);
		end
		else
		begin
			o_wake <= 1'b0;
		end
	end

endmodule // iec_ncs_filter

// ### iec_ctrl.v
// Interface select, enable and clock gate register bank
// Contract
// - Select code picks SPI, I2C or single-wire
// - Transceiver bit routes shared pin from DAC
// - Deglitch bit selects 1ms or 10ms filter
// - Bit 0 enables software watchdog
// - Bit 1 enables oscillator watchdog
// - Bit 2 enables cap clock flag monitor
// - Loopback bit enables loopback, forces resistive mode
// - Internal capacitors bit swaps sensor capacitors
// - EEPROM clock bit gates clock and access
// - Interface clock bit gates host interfaces
// - Activation or long chip select sets clock
// - Self-test bit runs test, blocks core RAM
// - Done flag then valid fail flag
`timescale 1ns/10ps
`include "iec_consts.vh"

module iec_ctrl
#(
	parameter DEGLITCH_SHORT_CYCLES = `IEC_DEGLITCH_SHORT_CYC,
	parameter DEGLITCH_LONG_CYCLES  = `IEC_DEGLITCH_LONG_CYC
)
(
	// Clock and reset
	input  wire       i_ref_clk,
	input  wire       i_rst,
	// Special-function register bus
	input  wire [7:0] i_sfr_addr,
	input  wire       i_sfr_wr,
	input  wire [7:0] i_sfr_wdata,
	input  wire       i_sfr_rd,
	output reg  [7:0] o_sfr_rdata,
	// Wake sources
	input  wire       i_single_wire_wake,
	input  wire       i_spi_chip_select_low_n,
	// RAM self-test engine
	input  wire       i_selftest_finish,
	input  wire       i_selftest_error,
	// Host interface routing
	output reg        o_spi_active,
	output reg        o_i2c_active,
	output reg        o_single_wire_active,
	output reg        o_first_dac_to_pin,
	output reg        o_transceiver_to_pin,
	output reg        o_deglitch_long,
	output reg        o_activation_irq,
	// Monitors and test features
	output reg        o_sw_watchdog_en,
	output reg        o_osc_watchdog_en,
	output reg        o_cap_clock_monitor_en,
	output reg        o_dac_loopback_en,
	output reg        o_afe_force_resistive,
	output reg        o_int_caps_en,
	output reg        o_ext_caps_en,
	// Clock gates and self-test
	output reg        o_eeprom_clk_en,
	output reg        o_eeprom_access_en,
	output reg        o_host_if_clk_en,
	output reg        o_selftest_run,
	output reg        o_cpu_ram_access_en
);

	localparam [`IEC_DEGLITCH_CNT_W-1:0] DG_SHORT =
		DEGLITCH_SHORT_CYCLES[`IEC_DEGLITCH_CNT_W-1:0];
	localparam [`IEC_DEGLITCH_CNT_W-1:0] DG_LONG  =
		DEGLITCH_LONG_CYCLES[`IEC_DEGLITCH_CNT_W-1:0];

	reg  [7:0]                     host_interface_control;
	reg  [7:0]                     monitor_and_test_enables;
	reg  [7:0]                     clock_gate_and_selftest_enables;
	reg                            selftest_done;
	reg                            selftest_fail;
	reg  [`IEC_DEGLITCH_CNT_W-1:0] deglitch_count;
	reg                            activation_pulse;
	reg  [7:0]                     next_host_if;
	reg  [7:0]                     next_enables;
	reg  [7:0]                     next_clk_gate;
	reg                            next_done;
	reg                            next_fail;
	reg  [7:0]                     next_rdata;
	reg  [`IEC_DEGLITCH_CNT_W-1:0] deglitch_limit;
	wire                           ncs_wake;
	wire                           wr_host_if;
	wire                           wr_enables;
	wire                           wr_clk_gate;
	wire                           selftest_start;

	////////////////////////////////////////////////////////////////////////
	// Chip-select wake detector

	iec_ncs_filter u_ncs_filter
	(
		.i_ref_clk               (i_ref_clk),
		.i_rst                   (i_rst),
		.i_spi_chip_select_low_n (i_spi_chip_select_low_n),
		.o_wake                  (ncs_wake)
	);

	////////////////////////////////////////////////////////////////////////
	// Write decode

	assign wr_host_if  = i_sfr_wr && (i_sfr_addr == `IEC_ADDR_HOST_IF);
	assign wr_enables  = i_sfr_wr && (i_sfr_addr == `IEC_ADDR_ENABLES);
	assign wr_clk_gate = i_sfr_wr && (i_sfr_addr == `IEC_ADDR_CLK_GATE);

	assign selftest_start = next_clk_gate[`IEC_CG_SELFTEST_BIT] &&
		!clock_gate_and_selftest_enables[`IEC_CG_SELFTEST_BIT];

	always @*
	begin
		next_host_if  = host_interface_control;
		next_enables  = monitor_and_test_enables;
		next_clk_gate = clock_gate_and_selftest_enables;
		if (wr_host_if)
			next_host_if = i_sfr_wdata & `IEC_MASK_HOST_IF;
		if (wr_enables)
			next_enables = i_sfr_wdata & `IEC_MASK_ENABLES;
		if (wr_clk_gate)
			next_clk_gate = i_sfr_wdata & `IEC_MASK_CLK_GATE;
		// Hardware wake beats a software clear in the same cycle
		if (activation_pulse || ncs_wake)
			next_clk_gate[`IEC_CG_HOST_IF_BIT] = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Self-test status: cleared on each new start, finish only counts once the self-test bit is already set

	always @*
	begin
		next_done = selftest_done;
		next_fail = selftest_fail;
		if (selftest_start)
		begin
			next_done = 1'b0;
			next_fail = 1'b0;
		end
		if (clock_gate_and_selftest_enables[`IEC_CG_SELFTEST_BIT] && i_selftest_finish)
		begin
			next_done = 1'b1;
			next_fail = i_selftest_error;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux, unmapped addresses read zero

	always @*
	begin
		next_rdata = 8'h00;
		case (i_sfr_addr)
			`IEC_ADDR_HOST_IF:       next_rdata = host_interface_control;
			`IEC_ADDR_ENABLES:       next_rdata = monitor_and_test_enables;
			`IEC_ADDR_CLK_GATE:      next_rdata = clock_gate_and_selftest_enables;
			`IEC_ADDR_SELFTEST_STAT:
			begin
				next_rdata[`IEC_ST_DONE_BIT] = selftest_done;
				next_rdata[`IEC_ST_FAIL_BIT] = selftest_fail;
			end
			default:                 next_rdata = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Activation deglitch filter on the single-wire pin

	always @*
	begin
		if (host_interface_control[`IEC_HIF_DEGLITCH_BIT])
			deglitch_limit = DG_LONG;
		else
			deglitch_limit = DG_SHORT;
	end

	// Counter saturates so one long level gives a single activation
	always @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			deglitch_count   <= {`IEC_DEGLITCH_CNT_W{1'b0}};
			activation_pulse <= 1'b0;
		end
		else if (!i_single_wire_wake)
		begin
			deglitch_count   <= {`IEC_DEGLITCH_CNT_W{1'b0}};
			activation_pulse <= 1'b0;
		end
		else if (deglitch_count < deglitch_limit)
		begin
			deglitch_count   <= deglitch_count + 1'b1;
			activation_pulse <= (deglitch_count == deglitch_limit - 1'b1);
		end
		else
		begin
			activation_pulse <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers and decoded outputs, outputs follow the stored value at once

	always @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			host_interface_control          <= `IEC_RST_HOST_IF;
			monitor_and_test_enables        <= `IEC_RST_ENABLES;
			clock_gate_and_selftest_enables <= `IEC_RST_CLK_GATE;
			selftest_done                   <= 1'b0;
			selftest_fail                   <= 1'b0;
			o_sfr_rdata                     <= 8'h00;
			o_spi_active                    <= 1'b1;
			o_i2c_active                    <= 1'b0;
			o_single_wire_active            <= 1'b0;
			o_first_dac_to_pin              <= 1'b1;
			o_transceiver_to_pin            <= 1'b0;
			o_deglitch_long                 <= 1'b0;
			o_activation_irq                <= 1'b0;
			o_sw_watchdog_en                <= 1'b0;
			o_osc_watchdog_en               <= 1'b0;
			o_cap_clock_monitor_en          <= 1'b0;
			o_dac_loopback_en               <= 1'b0;
			o_afe_force_resistive           <= 1'b0;
			o_int_caps_en                   <= 1'b0;
			o_ext_caps_en                   <= 1'b1;
			o_eeprom_clk_en                 <= 1'b0;
			o_eeprom_access_en              <= 1'b0;
			o_host_if_clk_en                <= 1'b0;
			o_selftest_run                  <= 1'b0;
			o_cpu_ram_access_en             <= 1'b1;
		end
		else
		begin
			host_interface_control          <= next_host_if;
			monitor_and_test_enables        <= next_enables;
			clock_gate_and_selftest_enables <= next_clk_gate;
			selftest_done                   <= next_done;
			selftest_fail                   <= next_fail;
			if (i_sfr_rd)
				o_sfr_rdata <= next_rdata;
			o_activation_irq <= activation_pulse;
			case (next_host_if[`IEC_HIF_SEL_MSB:`IEC_HIF_SEL_LSB])
				`IEC_SEL_I2C:
				begin
					o_spi_active         <= 1'b0;
					o_i2c_active         <= 1'b1;
					o_single_wire_active <= 1'b0;
				end
				`IEC_SEL_SINGLE_WIRE:
				begin
					o_spi_active         <= 1'b0;
					o_i2c_active         <= 1'b0;
					o_single_wire_active <= 1'b1;
				end
				default:
				begin
					o_spi_active         <= 1'b1;
					o_i2c_active         <= 1'b0;
					o_single_wire_active <= 1'b0;
				end
			endcase
			o_transceiver_to_pin   <= next_host_if[`IEC_HIF_XCR_BIT];
			o_first_dac_to_pin     <= !next_host_if[`IEC_HIF_XCR_BIT];
			o_deglitch_long        <= next_host_if[`IEC_HIF_DEGLITCH_BIT];
			o_sw_watchdog_en       <= next_enables[`IEC_EN_SW_WD_BIT];
			o_osc_watchdog_en      <= next_enables[`IEC_EN_OSC_WD_BIT];
			o_cap_clock_monitor_en <= next_enables[`IEC_EN_CAP_MON_BIT];
			o_dac_loopback_en      <= next_enables[`IEC_EN_LOOPBACK_BIT];
			o_afe_force_resistive  <= next_enables[`IEC_EN_LOOPBACK_BIT];
			o_int_caps_en          <= next_enables[`IEC_EN_INT_CAPS_BIT];
			o_ext_caps_en          <= !next_enables[`IEC_EN_INT_CAPS_BIT];
			o_eeprom_clk_en        <= next_clk_gate[`IEC_CG_EEPROM_BIT];
			o_eeprom_access_en     <= next_clk_gate[`IEC_CG_EEPROM_BIT];
			o_host_if_clk_en       <= next_clk_gate[`IEC_CG_HOST_IF_BIT];
			o_selftest_run         <= next_clk_gate[`IEC_CG_SELFTEST_BIT];
			o_cpu_ram_access_en    <= !next_clk_gate[`IEC_CG_SELFTEST_BIT];
		end
	end

endmodule // iec_ctrl

// ### iec_ctrl_asserts.sv
// Concurrent checks on the interface and enable control bank ports
`timescale 1ns/10ps
module iec_ctrl_asserts
(
	// Clock and reset
	input wire       i_ref_clk,
	input wire       i_rst,
	// Register bus
	input wire [7:0] i_sfr_addr,
	input wire       i_sfr_wr,
	input wire [7:0] i_sfr_wdata,
	input wire       i_sfr_rd,
	input wire [7:0] o_sfr_rdata,
	// Wake and routing
	input wire       i_spi_chip_select_low_n,
	input wire       o_spi_active,
	input wire       o_i2c_active,
	input wire       o_single_wire_active,
	input wire       o_first_dac_to_pin,
	input wire       o_transceiver_to_pin,
	input wire       o_deglitch_long,
	input wire       o_dac_loopback_en,
	input wire       o_afe_force_resistive,
	input wire       o_int_caps_en,
	input wire       o_ext_caps_en,
	input wire       o_host_if_clk_en,
	input wire       o_selftest_run,
	input wire       o_cpu_ram_access_en
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	////////////////////////////////////////////////////////////////////////////////
	// Saturates so a very long low period never wraps back to the trigger count
	reg [7:0] cs_low_cnt;
	always @(posedge i_ref_clk)
	begin
		if (i_rst || i_spi_chip_select_low_n)
			cs_low_cnt <= 8'h00;
		else if (cs_low_cnt != 8'hff)
			cs_low_cnt <= cs_low_cnt + 8'h01;
	end
	////////////////////////////////////////////////////////////////////////////////
	sequence s_wr_hif;
		i_sfr_wr && i_sfr_addr == 8'hd4;
	endsequence
	sequence s_wr_en;
		i_sfr_wr && i_sfr_addr == 8'hd5;
	endsequence
	sequence s_wr_cg;
		i_sfr_wr && i_sfr_addr == 8'hd6;
	endsequence
	sequence s_cs_long;
		cs_low_cnt == 8'h64;
	endsequence
	property p_sel_onehot;
		$onehot({o_spi_active, o_i2c_active, o_single_wire_active});
	endproperty
	property p_pin_route;
		s_wr_hif |=> o_transceiver_to_pin == $past(i_sfr_wdata[2])
			&& o_first_dac_to_pin != $past(i_sfr_wdata[2]);
	endproperty
	property p_deglitch;
		s_wr_hif |=> o_deglitch_long == $past(i_sfr_wdata[3]);
	endproperty
	property p_loopback;
		(o_dac_loopback_en == o_afe_force_resistive)
			and (s_wr_en |=> o_dac_loopback_en == $past(i_sfr_wdata[3]));
	endproperty
	property p_caps;
		(o_int_caps_en != o_ext_caps_en)
			and (s_wr_en |=> o_int_caps_en == $past(i_sfr_wdata[4]));
	endproperty
	property p_cs_wake;
		s_cs_long |=> o_host_if_clk_en;
	endproperty
	property p_ram_block;
		(o_selftest_run |-> !o_cpu_ram_access_en)
			and (s_wr_cg |=> o_selftest_run == $past(i_sfr_wdata[2]));
	endproperty
	property p_upper_zero;
		i_sfr_rd && i_sfr_addr == 8'hd4 |=> o_sfr_rdata[7:4] == 4'h0;
	endproperty
	a_sel_onehot: assert property (p_sel_onehot) else $error("select not one-hot");
	a_pin_route: assert property (p_pin_route) else $error("pin routing wrong");
	a_deglitch: assert property (p_deglitch) else $error("deglitch select wrong");
	a_loopback: assert property (p_loopback) else $error("loopback mismatch");
	a_caps: assert property (p_caps) else $error("capacitor select wrong");
	a_cs_wake: assert property (p_cs_wake) else $error("chip select wake missed");
	a_ram_block: assert property (p_ram_block) else $error("core RAM not blocked");
	a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");
endmodule // iec_ctrl_asserts

bind iec_ctrl iec_ctrl_asserts iec_ctrl_asserts_i (.i_ref_clk, .i_rst, .i_sfr_addr, .i_sfr_wr,
	.i_sfr_wdata, .i_sfr_rd, .o_sfr_rdata, .i_spi_chip_select_low_n, .o_spi_active,
	.o_i2c_active, .o_single_wire_active, .o_first_dac_to_pin, .o_transceiver_to_pin,
	.o_deglitch_long, .o_dac_loopback_en, .o_afe_force_resistive, .o_int_caps_en,
	.o_ext_caps_en, .o_host_if_clk_en, .o_selftest_run, .o_cpu_ram_access_en);

// ### iec_ctrl_test.sv
// Self-checking bench for the interface and enable control bank
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_fail++; \
	$display("Error %s expected %h seen %h", nm, exp, got); end end
module iec_ctrl_test;
	localparam SHORT = 8;
	localparam LONG  = 20;
	logic       i_ref_clk = 0;
	logic       i_rst = 1;
	logic [7:0] i_sfr_addr = 8'h00;
	logic       i_sfr_wr = 0;
	logic [7:0] i_sfr_wdata = 8'h00;
	logic       i_sfr_rd = 0;
	logic       i_single_wire_wake = 0;
	logic       i_spi_chip_select_low_n = 1;
	logic       i_selftest_finish = 0;
	logic       i_selftest_error = 0;
	wire  [7:0] o_sfr_rdata;
	wire        o_spi_active, o_i2c_active, o_single_wire_active, o_first_dac_to_pin;
	wire        o_transceiver_to_pin, o_deglitch_long, o_activation_irq, o_sw_watchdog_en;
	wire        o_osc_watchdog_en, o_cap_clock_monitor_en, o_dac_loopback_en, o_int_caps_en;
	wire        o_afe_force_resistive, o_ext_caps_en, o_eeprom_clk_en, o_eeprom_access_en;
	wire        o_host_if_clk_en, o_selftest_run, o_cpu_ram_access_en;
	int         n_fail = 0;
	int         cmp_count = 0;
	int         irq_cnt = 0;
	int         i;
	iec_ctrl #(.DEGLITCH_SHORT_CYCLES(SHORT), .DEGLITCH_LONG_CYCLES(LONG)) iec_ctrl_i (
		.i_ref_clk, .i_rst, .i_sfr_addr, .i_sfr_wr, .i_sfr_wdata, .i_sfr_rd, .o_sfr_rdata,
		.i_single_wire_wake, .i_spi_chip_select_low_n, .i_selftest_finish, .i_selftest_error,
		.o_spi_active, .o_i2c_active, .o_single_wire_active, .o_first_dac_to_pin,
		.o_transceiver_to_pin, .o_deglitch_long, .o_activation_irq, .o_sw_watchdog_en,
		.o_osc_watchdog_en, .o_cap_clock_monitor_en, .o_dac_loopback_en,
		.o_afe_force_resistive, .o_int_caps_en, .o_ext_caps_en, .o_eeprom_clk_en,
		.o_eeprom_access_en, .o_host_if_clk_en, .o_selftest_run, .o_cpu_ram_access_en);
	always #2.5 i_ref_clk = ~i_ref_clk;
	always @(negedge i_ref_clk)
		if (o_activation_irq === 1'b1)
			irq_cnt++;
	////////////////////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(negedge i_ref_clk);
	endtask
	// Strobes idle one cycle after each access so no edge sees them set twice
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_sfr_addr = a;
		i_sfr_wdata = d;
		i_sfr_wr = 1;
		cyc(1);
		i_sfr_wr = 0;
		cyc(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		i_sfr_addr = a;
		i_sfr_rd = 1;
		cyc(1);
		i_sfr_rd = 0;
		`CHK("rdata", exp, o_sfr_rdata)
		cyc(1);
	endtask
	task automatic fin(input logic e);
		i_selftest_finish = 1;
		i_selftest_error = e;
		cyc(1);
		i_selftest_finish = 0;
	endtask
	task automatic finish_test;
		$display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#100000;
		n_fail++;
		finish_test;
	end
	initial
	begin
		cyc(6);
		i_rst = 0;
		for (i = 0; i < 4; i++)
			rd(8'hd4 + 8'(i), 8'h00);
		`CHK("rst_out", 4'hf, {o_spi_active, o_first_dac_to_pin, o_ext_caps_en, o_cpu_ram_access_en})
		for (i = 0; i < 4; i++)
		begin
			wr(8'hd4, 8'(i));
			`CHK("sel", (i == 1) ? 3'h2 : (i == 2) ? 3'h1 : 3'h4, {o_spi_active, o_i2c_active, o_single_wire_active})
		end
		wr(8'hd4, 8'hff);
		rd(8'hd4, 8'h0f);
		`CHK("pin", 3'h5, {o_transceiver_to_pin, o_first_dac_to_pin, o_deglitch_long})
		for (i = 0; i < 5; i++)
		begin
			wr(8'hd5, 8'h01 << i);
			`CHK("en", {i != 4, i == 3, 5'(1 << i)}, {o_ext_caps_en, o_afe_force_resistive, o_int_caps_en, o_dac_loopback_en, o_cap_clock_monitor_en, o_osc_watchdog_en, o_sw_watchdog_en})
		end
		wr(8'hd5, 8'hff);
		rd(8'hd5, 8'h1f);
		wr(8'hd6, 8'hff);
		rd(8'hd6, 8'h07);
		`CHK("gate", 5'h1e, {o_eeprom_clk_en, o_eeprom_access_en, o_host_if_clk_en, o_selftest_run, o_cpu_ram_access_en})
		fin(1);
		rd(8'hd7, 8'h03);
		wr(8'hd6, 8'h00);
		`CHK("gate0", 5'h01, {o_eeprom_clk_en, o_eeprom_access_en, o_host_if_clk_en, o_selftest_run, o_cpu_ram_access_en})
		fin(0);
		wr(8'hd7, 8'hff);
		rd(8'hd7, 8'h03);
		wr(8'hd6, 8'h04);
		rd(8'hd7, 8'h00);
		fin(0);
		rd(8'hd7, 8'h01);
		wr(8'hd8, 8'hff);
		rd(8'hd8, 8'h00);
		for (i = 99; i <= 100; i++)
		begin
			wr(8'hd6, 8'h00);
			i_spi_chip_select_low_n = 0;
			cyc(i);
			i_spi_chip_select_low_n = 1;
			cyc(2);
			`CHK("cs_wake", i == 100, o_host_if_clk_en)
		end
		for (i = 0; i < 4; i++)
		begin
			wr(8'hd4, {4'h0, i[1], 3'h0});
			wr(8'hd6, 8'h00);
			irq_cnt = 0;
			i_single_wire_wake = 1;
			cyc(i[0] ? 30 : (i[1] ? LONG : SHORT) - 1);
			i_single_wire_wake = 0;
			cyc(3);
			`CHK("irq_cnt", i[0], irq_cnt)
			`CHK("act_wake", i[0], o_host_if_clk_en)
		end
		finish_test;
	end
endmodule // iec_ctrl_test
